// ==== tb/sep_link_properties.sv ====
`timescale 1ns/1ps
module sep_link_chk #(
	parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chip_sel,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic dev_out,
	input wire logic dev_out_oe,
	input wire logic serial_out
);
	int low_cnt_r;
	int ph_cnt_r;
	int busy_cnt_r;
	logic sk_q_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Deselect length, shift clock phase length and busy length
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			low_cnt_r <= 0;
		else if (chip_sel)
			low_cnt_r <= 0;
		else if (low_cnt_r < 1000)
			low_cnt_r <= low_cnt_r + 1;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sk_q_r <= 1'b0;
		else
			sk_q_r <= shift_clock;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ph_cnt_r <= 0;
		else if (shift_clock != sk_q_r)
			ph_cnt_r <= 0;
		else if (ph_cnt_r < 1000)
			ph_cnt_r <= ph_cnt_r + 1;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			busy_cnt_r <= 0;
		else if (chip_sel && dev_out_oe && !dev_out)
			busy_cnt_r <= busy_cnt_r + 1;
		else
			busy_cnt_r <= 0;
	end
	idle_release_a: assert property (!chip_sel [*8] |-> !dev_out_oe)
		else $error("output driven while deselected");
	cs_end_a: assert property ($fell(chip_sel) |-> ##[1:8] !dev_out_oe)
		else $error("output kept after select fell");
	desel_gap_a: assert property ($rose(chip_sel) |-> low_cnt_r >= 20)
		else $error("deselect gap too short");
	sk_quiet_a: assert property (!chip_sel |-> !shift_clock)
		else $error("shift clock high while deselected");
	si_hold_a: assert property ($rose(shift_clock) |-> $stable(serial_in) && chip_sel)
		else $error("serial input moved at clock rise");
	sk_phase_a: assert property (shift_clock != sk_q_r |-> ph_cnt_r >= 24)
		else $error("shift clock phase too short");
	// Mid-frame enable is the read dummy bit; early enable may show ready
	oe_low_first_a: assert property ($rose(dev_out_oe) && $past(chip_sel, 8) |-> !dev_out)
		else $error("output enabled without low first");
	poll_quiet_a: assert property ($rose(chip_sel) && !serial_in |->
		(!serial_in && !shift_clock) until !chip_sel)
		else $error("activity during status poll");
	busy_bound_a: assert property (busy_cnt_r <= PROG_CYCLES)
		else $error("busy shown too long");
	cover property (chip_sel && dev_out_oe && !dev_out ##1 serial_out);
	cover property ($rose(dev_out_oe) ##[1:60] dev_out);
	cover property (chip_sel && ph_cnt_r == 500);
endmodule

// ==== tb/sep_tb.sv ====
`timescale 1ns/1ps
module sep_tb;
	localparam int PROG = 1100;
	logic sys_clk;
	logic rst;
	logic cmd_valid, cmd_ready, cmd_done, rd_valid, rd_ready;
	sep_pkg::sep_cmd_t cmd_code;
	logic [9:0] cmd_addr;
	logic [15:0] cmd_data, rd_data, x2;
	logic [7:0] cmd_words;
	logic [15:0] mem [1024];
	logic [31:0] lf;
	int n_fail = 0;
	int num_checks = 0;
	int n_cmd = 0;
	int n_done = 0;
	sep_link_if sep_link_if_i();
	sep_link_if sep_link_if_b_i();
	sep_dev #(.PROG_CYCLES(PROG)) sep_dev_i (.sys_clk(sys_clk), .rst(rst),
		.link(sep_link_if_i.dev));
	sep_dev #(.PROG_CYCLES(PROG)) sep_dev_b_i (.sys_clk(sys_clk), .rst(rst),
		.link(sep_link_if_b_i.dev));
	sep_host #(.WORDS_W(8)) sep_host_i (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_words(cmd_words), .cmd_done(cmd_done), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .link(sep_link_if_i.host));
	sep_link_chk #(.PROG_CYCLES(PROG)) sep_link_chk_i (.sys_clk(sys_clk), .rst(rst),
		.chip_sel(sep_link_if_i.chip_sel), .shift_clock(sep_link_if_i.shift_clock),
		.serial_in(sep_link_if_i.serial_in), .dev_out(sep_link_if_i.dev_out),
		.dev_out_oe(sep_link_if_i.dev_out_oe), .serial_out(sep_link_if_i.serial_out));
	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk)
		if (cmd_done === 1'b1)
			n_done++;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] fr(input logic [1:0] op, input logic [9:0] a,
		input logic [15:0] d);
		return {3'h0, 1'b1, op, a, d};
	endfunction
	function automatic logic [15:0] exp_at(input logic [9:0] a);
		return mem[a];
	endfunction
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic hidle();
		int t;
		t = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			t++;
		end
		while (cmd_ready !== 1'b1 && t < 40000);
	endtask
	task automatic hcmd(input sep_pkg::sep_cmd_t c, input logic [9:0] a,
		input logic [15:0] d, input logic [7:0] w);
		hidle();
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_words <= w;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		n_cmd++;
	endtask
	task automatic pop(input logic [15:0] exp);
		int t;
		t = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			t++;
		end
		while (rd_valid !== 1'b1 && t < 3000);
		chk_word(rd_data, exp);
		@(posedge sys_clk);
		rd_ready <= 1'b1;
		@(posedge sys_clk);
		rd_ready <= 1'b0;
	endtask
	// Bit-banged frame on the second link, output sampled late in each high phase
	task automatic bb(input logic [31:0] v, input int n, input logic cs, input logic poll,
		output logic [31:0] sh);
		int t;
		sh = 32'h0;
		@(posedge sys_clk);
		sep_link_if_b_i.chip_sel <= cs;
		if (poll)
		begin
			t = 0;
			while (sep_link_if_b_i.serial_out !== 1'b1 && t < 3000)
			begin
				@(posedge sys_clk);
				#1;
				t++;
			end
			chk_bit(sep_link_if_b_i.serial_out, 1'b1);
		end
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge sys_clk);
			sep_link_if_b_i.serial_in <= v[i];
			repeat (25) @(posedge sys_clk);
			sep_link_if_b_i.shift_clock <= 1'b1;
			repeat (20) @(posedge sys_clk);
			#1;
			sh = {sh[30:0], sep_link_if_b_i.serial_out};
			repeat (5) @(posedge sys_clk);
			sep_link_if_b_i.shift_clock <= 1'b0;
		end
		@(posedge sys_clk);
		sep_link_if_b_i.chip_sel <= 1'b0;
		sep_link_if_b_i.serial_in <= 1'b0;
		repeat (30) @(posedge sys_clk);
	endtask
	task automatic rd2(input logic [9:0] a, input logic [15:0] e, input logic poll);
		logic [31:0] sh;
		bb(fr(sep_pkg::OPC_READ, a, 16'h0000), poll ? 32 : 29, 1'b1, poll, sh);
		chk_word(sh[15:0], e);
		chk_bit(sh[16], 1'b0);
	endtask
	task automatic dev2_seq();
		logic [31:0] sh;
		bb(fr(sep_pkg::OPC_WRITE, 10'h003, 16'hA55A), 29, 1'b1, 1'b0, sh);
		bb(fr(sep_pkg::OPC_EXT, {sep_pkg::EXT_EN, 8'h00}, 16'h0) >> 16, 13, 1'b1, 1'b0, sh);
		bb(fr(sep_pkg::OPC_WRITE, 10'h003, 16'h0F0F), 29, 1'b0, 1'b0, sh);
		bb(fr(sep_pkg::OPC_WRITE, 10'h003, 16'h1234) << 1, 30, 1'b1, 1'b0, sh);
		bb(fr(sep_pkg::OPC_WRITE, 10'h003, 16'h4321) >> 1, 28, 1'b1, 1'b0, sh);
		repeat (1200) @(posedge sys_clk);
		rd2(10'h003, 16'hFFFF, 1'b0);
		bb(fr(sep_pkg::OPC_WRITE, 10'h007, x2), 32, 1'b1, 1'b0, sh);
		rd2(10'h007, x2, 1'b1);
		bb(fr(sep_pkg::OPC_EXT, {sep_pkg::EXT_DIS, 8'h00}, 16'h0) >> 16, 13, 1'b1, 1'b0, sh);
		bb(fr(sep_pkg::OPC_WRITE, 10'h007, ~x2), 29, 1'b1, 1'b0, sh);
		repeat (1200) @(posedge sys_clk);
		rd2(10'h007, x2, 1'b0);
	endtask
	task automatic host_seq();
		logic [9:0] a;
		hcmd(sep_pkg::SEP_CMD_READ, 10'h000, 16'h0000, 8'h01);
		pop(exp_at(10'h000));
		hcmd(sep_pkg::SEP_CMD_PROG_EN, lf[9:0], 16'h0000, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			lf = lfsr(lf);
			a = (k == 0) ? 10'h3FF : lf[9:0];
			hcmd(sep_pkg::SEP_CMD_WRITE, a, lf[31:16], 8'h00);
			mem[a] = lf[31:16];
			hcmd(sep_pkg::SEP_CMD_READ, a, 16'h0000, 8'h02);
			pop(exp_at(a));
			pop(exp_at(a + 10'h001));
			hcmd(sep_pkg::SEP_CMD_ERASE, a, lf[15:0], 8'h00);
			mem[a] = 16'hFFFF;
			hcmd(sep_pkg::SEP_CMD_READ, a, 16'h0000, 8'h01);
			pop(exp_at(a));
		end
		lf = lfsr(lf);
		hcmd(sep_pkg::SEP_CMD_CHIP_WRITE, lf[25:16], lf[15:0], 8'h00);
		foreach (mem[i])
			mem[i] = lf[15:0];
		hcmd(sep_pkg::SEP_CMD_READ, lf[9:0], 16'h0000, 8'h01);
		pop(exp_at(lf[9:0]));
		hcmd(sep_pkg::SEP_CMD_CHIP_ERASE, lf[31:22], 16'h0000, 8'h00);
		foreach (mem[i])
			mem[i] = 16'hFFFF;
		hcmd(sep_pkg::SEP_CMD_READ, 10'h3FC, 16'h0000, 8'h14);
		repeat (15000) @(posedge sys_clk);
		#1;
		chk_bit(cmd_ready, 1'b0);
		chk_bit(rd_valid, 1'b1);
		for (int k = 0; k < 20; k++)
			pop(exp_at(10'h3FC + 10'(k)));
		hcmd(sep_pkg::SEP_CMD_PROG_DIS, 10'h000, 16'h0000, 8'h00);
		hidle();
		chk_word(16'(n_done), 16'(n_cmd));
	endtask
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end
	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_code = sep_pkg::SEP_CMD_READ;
		cmd_addr = 10'h000;
		cmd_data = 16'h0000;
		cmd_words = 8'h00;
		rd_ready = 1'b0;
		sep_link_if_b_i.chip_sel = 1'b0;
		sep_link_if_b_i.shift_clock = 1'b0;
		sep_link_if_b_i.serial_in = 1'b0;
		lf = 32'h2F3AD0CF;
		foreach (mem[i])
			mem[i] = 16'hFFFF;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (1100) @(posedge sys_clk);
		lf = lfsr(lf);
		x2 = lf[15:0];
		fork
			host_seq();
			dev2_seq();
		join
		wrap_up();
	end
endmodule

// ==== verilog/sep_dev.sv ====
`timescale 1ns/1ps
// Function
// (R1) Start, opcode, address, data on rising clock
// (R2) Chip select fall ends command input
// (R3) Chip select low: ignore clock and input
// (R4) First high sample after select is start
// (R5) Low samples before start are dummy clocks
// (R6) Host may pad with leading dummy clocks
// (R7) High input while showing ready restarts decode
// (R8) Host holds input low while polling
// (R9) Read: drive low after last address bit
// (R10) Then sixteen bits out, MSB first
// (R11) Programming starts on chip select fall
// (R12) Programming ignores clock and input
// (R13) Host starts commands only on high/released output
// (R14) Programming only when write-enabled
// (R15) Programming cycle ends within 4 ms
// (R16) All words start as all ones
// (R17) Selected during programming: low busy, high ready
// (R18) Enable/disable take effect at chip select fall
// (R19) Wrong clock count cancels the command
// (R20) Continued clocking streams next words
// (R21) Ten-bit address; chip commands take any
module sep_dev #(
	parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	sep_link_if.dev link
);
	typedef enum logic [4:0] {
		ST_INIT = 5'b00001,
		ST_IDLE = 5'b00010,
		ST_CMD = 5'b00100,
		ST_READ = 5'b01000,
		ST_PROG = 5'b10000
	} sep_dev_state_t;

	localparam int PW = $clog2(PROG_CYCLES + 1);

	logic [15:0] mem [0:sep_pkg::WORDS-1];
	sep_dev_state_t state_r;
	logic cs_m_r, cs_s_r, cs_d_r;
	logic sk_m_r, sk_s_r, sk_d_r;
	logic di_m_r, di_s_r;
	logic [4:0] bits_r;
	logic [27:0] shift_r;
	logic prog_en_r;
	logic ready_r;
	logic [9:0] addr_r;
	logic [15:0] rd_word_r;
	logic [3:0] rd_cnt_r;
	logic [PW-1:0] prog_cnt_r;
	logic wr_busy_r;
	logic wr_all_r;
	logic [9:0] wr_idx_r;
	logic [15:0] wr_data_r;
	logic do_r;
	logic do_oe_r;

	logic sk_rise, cs_fall, cs_hi, rd_latch, cmd_ok, cmd_long;
	logic [1:0] op, ext;
	logic [9:0] cmd_addr, rd_addr, next_addr;

	// Long frames carry data: word write and chip write
	function automatic logic is_long(input logic [1:0] o, input logic [1:0] e);
		is_long = (o == sep_pkg::OPC_WRITE) || (o == sep_pkg::OPC_EXT && e == sep_pkg::EXT_CHIP_WRITE);
	endfunction

	assign sk_rise = sk_s_r & ~sk_d_r;
	assign cs_fall = ~cs_s_r & cs_d_r;
	assign cs_hi = cs_s_r;
	assign cmd_long = (bits_r == sep_pkg::CNT_LONG);
	assign op = cmd_long ? shift_r[27:26] : shift_r[11:10];
	assign ext = cmd_long ? shift_r[25:24] : shift_r[9:8];
	assign cmd_addr = cmd_long ? shift_r[25:16] : shift_r[9:0];
	// Exact clock count per command, reads never program
	assign cmd_ok = (op != sep_pkg::OPC_READ) &&
		(is_long(op, ext) ? cmd_long : (bits_r == sep_pkg::CNT_SHORT)); // see (R19)
	assign rd_addr = {shift_r[8:0], di_s_r};
	assign rd_latch = (state_r == ST_CMD) && cs_hi && sk_rise &&
		bits_r == sep_pkg::CNT_RD_LATCH && shift_r[10:9] == sep_pkg::OPC_READ;
	assign next_addr = addr_r + 10'h001;

	// Pin synchronisers
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			{cs_m_r, cs_s_r, cs_d_r} <= 3'h0;
			{sk_m_r, sk_s_r, sk_d_r} <= 3'h0;
			{di_m_r, di_s_r} <= 2'h0;
		end
		else
		begin
			{cs_m_r, cs_s_r, cs_d_r} <= {link.chip_sel, cs_m_r, cs_s_r};
			{sk_m_r, sk_s_r, sk_d_r} <= {link.shift_clock, sk_m_r, sk_s_r};
			{di_m_r, di_s_r} <= {link.serial_in, di_m_r};
		end
	end

	// Command sequencer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_INIT;
			bits_r <= 5'h00;
			shift_r <= 28'h0000000;
		end
		else
		begin
			case (state_r)
				ST_INIT:
				begin
					if (!wr_busy_r)
						state_r <= ST_IDLE;
				end
				ST_IDLE:
				begin
					// Low samples are dummy clocks; first high sample is the start
					if (cs_hi && sk_rise && di_s_r) // see (R3) (R4) (R5) (R7)
					begin
						state_r <= ST_CMD;
						bits_r <= 5'h00;
						shift_r <= 28'h0000000;
					end
				end
				ST_CMD:
				begin
					if (!cs_hi) // see (R2) (R3)
					begin
						if (cs_fall && cmd_ok && prog_en_r && op != sep_pkg::OPC_EXT) // see (R11) (R14)
							state_r <= ST_PROG;
						else if (cs_fall && cmd_ok && prog_en_r &&
							(ext == sep_pkg::EXT_CHIP_WRITE || ext == sep_pkg::EXT_CHIP_ERASE))
							state_r <= ST_PROG;
						else
							state_r <= ST_IDLE;
					end
					else if (rd_latch) // see (R9)
						state_r <= ST_READ;
					else if (sk_rise) // see (R1)
					begin
						shift_r <= {shift_r[26:0], di_s_r};
						if (bits_r != 5'h1F)
							bits_r <= bits_r + 5'h01;
					end
				end
				ST_READ:
				begin
					if (!cs_hi)
						state_r <= ST_IDLE;
				end
				ST_PROG:
				begin
					if (prog_cnt_r == '0 && !wr_busy_r) // see (R12) (R15)
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Write-enabled state, power-up disabled
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prog_en_r <= 1'b0;
		else if (state_r == ST_CMD && cs_fall && cmd_ok && op == sep_pkg::OPC_EXT) // see (R18) (R21)
		begin
			if (ext == sep_pkg::EXT_EN)
				prog_en_r <= 1'b1;
			else if (ext == sep_pkg::EXT_DIS)
				prog_en_r <= 1'b0;
		end
	end

	// Ready flag shown until the next start bit
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ready_r <= 1'b0;
		else if (state_r == ST_PROG && prog_cnt_r == '0 && !wr_busy_r)
			ready_r <= 1'b1;
		else if (state_r == ST_IDLE && cs_hi && sk_rise && di_s_r) // see (R7)
			ready_r <= 1'b0;
	end

	// Programming timer and memory write sweep
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			prog_cnt_r <= '0;
			wr_busy_r <= 1'b1;
			wr_all_r <= 1'b1;
			wr_idx_r <= 10'h000;
			wr_data_r <= sep_pkg::ERASED_WORD; // see (R16)
		end
		else if (state_r == ST_CMD && cs_fall && cmd_ok && prog_en_r && op != sep_pkg::OPC_EXT)
		begin
			prog_cnt_r <= PW'(PROG_CYCLES - 1); // see (R15)
			wr_busy_r <= 1'b1;
			wr_all_r <= 1'b0;
			wr_data_r <= (op == sep_pkg::OPC_WRITE) ? shift_r[15:0] : sep_pkg::ERASED_WORD;
		end
		else if (state_r == ST_CMD && cs_fall && cmd_ok && prog_en_r &&
			(ext == sep_pkg::EXT_CHIP_WRITE || ext == sep_pkg::EXT_CHIP_ERASE)) // see (R21)
		begin
			prog_cnt_r <= PW'(PROG_CYCLES - 1);
			wr_busy_r <= 1'b1;
			wr_all_r <= 1'b1;
			wr_idx_r <= 10'h000;
			wr_data_r <= (ext == sep_pkg::EXT_CHIP_WRITE) ? shift_r[15:0] : sep_pkg::ERASED_WORD;
		end
		else
		begin
			if (prog_cnt_r != '0)
				prog_cnt_r <= prog_cnt_r - PW'(1);
			if (wr_busy_r)
			begin
				wr_idx_r <= wr_idx_r + 10'h001;
				if (!wr_all_r || wr_idx_r == 10'h3FF)
					wr_busy_r <= 1'b0;
			end
		end
	end

	// Target address of a single-word command
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			addr_r <= 10'h000;
		else if (rd_latch)
			addr_r <= rd_addr;
		else if (state_r == ST_READ && cs_hi && sk_rise && rd_cnt_r == 4'hF)
			addr_r <= next_addr; // see (R20)
		else if (state_r == ST_CMD && cs_fall)
			addr_r <= cmd_addr;
	end

	always_ff @(posedge sys_clk)
	begin
		if (wr_busy_r)
			mem[wr_all_r ? wr_idx_r : addr_r] <= wr_data_r;
	end

	// Read word shifter
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_word_r <= 16'h0000;
			rd_cnt_r <= 4'h0;
		end
		else if (rd_latch)
		begin
			rd_word_r <= mem[rd_addr];
			rd_cnt_r <= 4'h0;
		end
		else if (state_r == ST_READ && cs_hi && sk_rise)
		begin
			rd_cnt_r <= rd_cnt_r + 4'h1;
			if (rd_cnt_r == 4'hF)
				rd_word_r <= mem[next_addr]; // see (R20)
			else
				rd_word_r <= {rd_word_r[14:0], 1'b0}; // see (R10)
		end
	end

	// Serial output driver
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			do_r <= 1'b0;
			do_oe_r <= 1'b0;
		end
		else if (!cs_hi)
			do_oe_r <= 1'b0;
		else
		begin
			case (state_r)
				ST_CMD:
				begin
					do_r <= 1'b0;
					do_oe_r <= rd_latch; // see (R9)
				end
				ST_READ:
				begin
					do_oe_r <= 1'b1;
					if (sk_rise)
						do_r <= rd_word_r[15]; // see (R10)
				end
				ST_PROG:
				begin
					do_r <= 1'b0; // see (R17)
					do_oe_r <= 1'b1;
				end
				ST_IDLE:
				begin
					do_r <= 1'b1; // see (R17)
					do_oe_r <= ready_r && !(sk_rise && di_s_r);
				end
				default:
					do_oe_r <= 1'b0;
			endcase
		end
	end

	assign link.dev_out = do_r;
	assign link.dev_out_oe = do_oe_r;
endmodule

// ==== verilog/sep_host.sv ====
`timescale 1ns/1ps
module sep_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] buf_r [0:DEPTH-1];
	logic [AW:0] wp_r, rp_r;
	logic push, pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
	assign out_valid = (wp_r != rp_r);
	assign out_data = buf_r[rp_r[AW-1:0]];

	always_ff @(posedge sys_clk)
	begin
		if (push)
			buf_r[wp_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + (AW+1)'(1);
			if (pop)
				rp_r <= rp_r + (AW+1)'(1);
		end
	end
endmodule

module sep_host #(
	parameter int WORDS_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sep_pkg::sep_cmd_t cmd_code,
	input wire logic [9:0] cmd_addr,
	input wire logic [15:0] cmd_data,
	input wire logic [WORDS_W-1:0] cmd_words,
	output logic cmd_done,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [15:0] rd_data,
	sep_link_if.host link
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_LOW = 5'b00010,
		H_HIGH = 5'b00100,
		H_POLL = 5'b01000,
		H_DESEL = 5'b10000
	} sep_host_state_t;

	sep_host_state_t state_r;
	logic do_m_r, do_s_r;
	logic cs_r, sk_r, di_r;
	logic [sep_pkg::TX_W-1:0] tx_r;
	logic [11:0] bit_r, nbits_r;
	logic rd_r, poll_r;
	logic [7:0] tim_r;
	logic [15:0] rx_r;
	logic [3:0] rx_cnt_r;
	logic push_r;
	logic fifo_in_ready;
	logic [28:0] frame;
	logic [WORDS_W-1:0] nwords;

	assign nwords = (cmd_words == '0) ? WORDS_W'(1) : cmd_words;

	// Assembles start, opcode, address and data, left aligned
	always_comb
	begin
		case (cmd_code)
			sep_pkg::SEP_CMD_READ: frame = {1'b1, sep_pkg::OPC_READ, cmd_addr, 16'h0000};
			sep_pkg::SEP_CMD_WRITE: frame = {1'b1, sep_pkg::OPC_WRITE, cmd_addr, cmd_data};
			sep_pkg::SEP_CMD_ERASE: frame = {1'b1, sep_pkg::OPC_ERASE, cmd_addr, 16'h0000};
			sep_pkg::SEP_CMD_CHIP_WRITE:
				frame = {1'b1, sep_pkg::OPC_EXT, sep_pkg::EXT_CHIP_WRITE, cmd_addr[7:0], cmd_data};
			sep_pkg::SEP_CMD_CHIP_ERASE:
				frame = {1'b1, sep_pkg::OPC_EXT, sep_pkg::EXT_CHIP_ERASE, cmd_addr[7:0], 16'h0000};
			sep_pkg::SEP_CMD_PROG_EN:
				frame = {1'b1, sep_pkg::OPC_EXT, sep_pkg::EXT_EN, cmd_addr[7:0], 16'h0000};
			default: frame = {1'b1, sep_pkg::OPC_EXT, sep_pkg::EXT_DIS, cmd_addr[7:0], 16'h0000};
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			{do_m_r, do_s_r} <= 2'h0;
		else
			{do_m_r, do_s_r} <= {link.serial_out, do_m_r};
	end

	// Link sequencer and shift clock divider
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= H_DESEL;
			cs_r <= 1'b0;
			sk_r <= 1'b0;
			di_r <= 1'b0;
			tx_r <= '0;
			bit_r <= 12'h000;
			nbits_r <= 12'h000;
			rd_r <= 1'b0;
			poll_r <= 1'b0;
			tim_r <= 8'(sep_pkg::DESEL_CYCLES - 1);
			cmd_ready <= 1'b0;
			cmd_done <= 1'b0;
		end
		else
		begin
			cmd_done <= 1'b0;
			case (state_r)
				H_IDLE:
				begin
					// Only reached with the output released or ready
					if (cmd_valid) // see (R13)
					begin
						cmd_ready <= 1'b0;
						cs_r <= 1'b1;
						tx_r <= frame; // see (R1)
						di_r <= 1'b1;
						bit_r <= 12'h000;
						rd_r <= (cmd_code == sep_pkg::SEP_CMD_READ);
						poll_r <= (cmd_code != sep_pkg::SEP_CMD_READ) &&
							(cmd_code != sep_pkg::SEP_CMD_PROG_EN) &&
							(cmd_code != sep_pkg::SEP_CMD_PROG_DIS);
						if (cmd_code == sep_pkg::SEP_CMD_READ)
							nbits_r <= sep_pkg::HDR_BITS + 12'({nwords, 4'h0});
						else if (cmd_code == sep_pkg::SEP_CMD_WRITE || cmd_code == sep_pkg::SEP_CMD_CHIP_WRITE)
							nbits_r <= sep_pkg::CMD_BITS_LONG;
						else
							nbits_r <= sep_pkg::CMD_BITS_SHORT;
						tim_r <= 8'(sep_pkg::SK_HALF_CYCLES - 1);
						state_r <= H_LOW;
					end
				end
				H_LOW:
				begin
					if (tim_r != 8'h00)
						tim_r <= tim_r - 8'h01;
					else if (fifo_in_ready || !rd_r)
					begin
						sk_r <= 1'b1;
						tim_r <= 8'(sep_pkg::SK_HALF_CYCLES - 1);
						state_r <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					if (tim_r != 8'h00)
						tim_r <= tim_r - 8'h01;
					else
					begin
						sk_r <= 1'b0;
						tx_r <= {tx_r[sep_pkg::TX_W-2:0], 1'b0};
						di_r <= tx_r[sep_pkg::TX_W-2];
						bit_r <= bit_r + 12'h001;
						tim_r <= 8'(sep_pkg::SK_HALF_CYCLES - 1);
						state_r <= H_LOW;
						if (bit_r == nbits_r - 12'h001)
						begin
							// Chip select fall ends input and starts programming
							cs_r <= 1'b0; // see (R2) (R11)
							di_r <= 1'b0;
							cmd_done <= !poll_r;
							tim_r <= 8'(sep_pkg::DESEL_CYCLES - 1);
							state_r <= H_DESEL;
						end
					end
				end
				H_POLL:
				begin
					di_r <= 1'b0; // see (R8)
					if (do_s_r) // see (R17)
					begin
						cs_r <= 1'b0;
						poll_r <= 1'b0;
						cmd_done <= 1'b1;
						tim_r <= 8'(sep_pkg::DESEL_CYCLES - 1);
						state_r <= H_DESEL;
					end
				end
				H_DESEL:
				begin
					if (tim_r != 8'h00)
						tim_r <= tim_r - 8'h01; // see (R2)
					else if (poll_r)
					begin
						cs_r <= 1'b1;
						state_r <= H_POLL;
					end
					else
					begin
						cmd_ready <= 1'b1;
						state_r <= H_IDLE;
					end
				end
				default:
					state_r <= H_DESEL;
			endcase
		end
	end

	// Read data capture at falling edges after the dummy low bit
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_r <= 16'h0000;
			rx_cnt_r <= 4'h0;
			push_r <= 1'b0;
		end
		else
		begin
			push_r <= 1'b0;
			if (state_r == H_IDLE)
				rx_cnt_r <= 4'h0;
			else if (state_r == H_HIGH && tim_r == 8'h00 && rd_r && bit_r >= sep_pkg::HDR_BITS)
			begin
				rx_r <= {rx_r[14:0], do_s_r}; // see (R10)
				rx_cnt_r <= rx_cnt_r + 4'h1;
				push_r <= (rx_cnt_r == 4'hF); // see (R20)
			end
		end
	end

	sep_fifo #(
		.WIDTH(16),
		.DEPTH(sep_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data(rx_r),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	assign link.chip_sel = cs_r;
	assign link.shift_clock = sk_r;
	assign link.serial_in = di_r;
endmodule

// ==== verilog/sep_link_if.sv ====
`timescale 1ns/1ps
interface sep_link_if;
	logic chip_sel;
	logic shift_clock;
	logic serial_in;
	logic dev_out;
	logic dev_out_oe;
	logic serial_out;
	// Undriven output line is pulled low
	assign serial_out = dev_out_oe & dev_out;
	modport dev (
		input chip_sel,
		input shift_clock,
		input serial_in,
		output dev_out,
		output dev_out_oe
	);
	modport host (
		output chip_sel,
		output shift_clock,
		output serial_in,
		input serial_out
	);
endinterface

// ==== verilog/sep_pkg.sv ====
package sep_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int WORDS = 1024;
	localparam int FIFO_DEPTH = 16;
	// Opcode field and extended codes held in the top two address bits
	localparam logic [1:0] OPC_EXT = 2'h0;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_READ = 2'h2;
	localparam logic [1:0] OPC_ERASE = 2'h3;
	localparam logic [1:0] EXT_DIS = 2'h0;
	localparam logic [1:0] EXT_CHIP_WRITE = 2'h1;
	localparam logic [1:0] EXT_CHIP_ERASE = 2'h2;
	localparam logic [1:0] EXT_EN = 2'h3;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	// Device clocks counted after the start bit; host bit counts include it
	localparam logic [4:0] CNT_SHORT = 5'h0C;
	localparam logic [4:0] CNT_LONG = 5'h1C;
	localparam logic [4:0] CNT_RD_LATCH = 5'h0B;
	localparam logic [11:0] HDR_BITS = 12'h00D;
	localparam logic [11:0] CMD_BITS_SHORT = 12'h00D;
	localparam logic [11:0] CMD_BITS_LONG = 12'h01D;
	localparam int TX_W = 29;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_TYP_NS = 2000000;
	localparam int PROG_TIME_MAX_NS = 4000000;
	localparam int PROG_CYCLES = PROG_TIME_TYP_NS / CLK_PERIOD_NS;
	localparam int DESEL_TIME_NS = 200;
	localparam int DESEL_CYCLES = (DESEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SK_FREQ_MAX_KHZ = 2000;
	localparam int SK_HALF_NS = 1000000 / (2 * SK_FREQ_MAX_KHZ);
	localparam int SK_HALF_CYCLES = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		SEP_CMD_READ = 3'h0,
		SEP_CMD_WRITE = 3'h1,
		SEP_CMD_ERASE = 3'h2,
		SEP_CMD_CHIP_WRITE = 3'h3,
		SEP_CMD_CHIP_ERASE = 3'h4,
		SEP_CMD_PROG_EN = 3'h5,
		SEP_CMD_PROG_DIS = 3'h6
	} sep_cmd_t;
endpackage
